//--- aioc_pkg.sv
// Constants, register map and types for the analog I/O channel configuration block
// Notes on behaviour
// - Inputs default force-off: on module failure every input channel value reads zero.
// - Inputs hold option: with hold set, on module failure every input channel value keeps its last value.
// - Status length accepts only 0 or 32; zero disables status, 32 enables it.
// - With module diagnostics on, 32 diagnostic bits per channel, used or not.
// - Each channel has a two-word value area in the input or output table.
// - Output range type disabled by default; channel drives only when voltage/current is chosen.
// - Output range: 0..+10 V default, -10..+10 V, 4..20 mA, 0..20 mA.
// - Integer output format takes the low word and ignores the high word.
// - Six events trigger the output default action.
// - Force-to-default (default) drives the default value until a good reconfiguration.
// - Value format defaults to 32-bit float; 16-bit integer is the alternative.
// - Module diagnostics default off; diagnostics and faults enabled per channel.
// - Integer input format fills the upper word with the sign extension.
// - Hold-last-state keeps the last output state until a good reconfiguration.
`default_nettype none
package aioc_pkg;
	localparam int N_IN  = 4;
	localparam int N_OUT = 2;
	localparam int N_CH  = N_IN + N_OUT;
	localparam int N_EV  = 6;
	localparam int N_IRQ = 3;

	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_OCFG     = 8'h04;
	localparam logic [7:0] OFF_CHEN     = 8'h08;
	localparam logic [7:0] OFF_INT_STAT = 8'h0C;
	localparam logic [7:0] OFF_INT_MASK = 8'h10;
	localparam logic [7:0] OFF_STATE    = 8'h14;
	localparam logic [7:0] OFF_DFLT0    = 8'h18;
	localparam logic [7:0] OFF_DFLT1    = 8'h1C;
	localparam logic [7:0] OFF_RECONF   = 8'h20;

	localparam int CTRL_IN_HOLD   = 0;
	localparam int CTRL_OUT_HOLD  = 1;
	localparam int CTRL_FMT_INT   = 2;
	localparam int CTRL_MOD_DIAG  = 3;
	localparam int CTRL_STLEN_LSB = 8;
	localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_FF0F;
	localparam logic [7:0]  STATUS_LEN_ON = 8'h20;

	localparam int OCFG_STRIDE = 4;
	localparam int OCFG_EN     = 0;
	localparam int OCFG_RNG    = 1;
	localparam logic [31:0] OCFG_RST = 32'h0000_0000;
	localparam int CHEN_FLT_LSB = 8;

	localparam logic [1:0] RNG_0_10V  = 2'h0;
	localparam logic [1:0] RNG_PM10V  = 2'h1;
	localparam logic [1:0] RNG_4_20MA = 2'h2;
	localparam logic [1:0] RNG_0_20MA = 2'h3;

	localparam int IRQ_DEFAULT = 0;
	localparam int IRQ_FAIL    = 1;
	localparam int IRQ_RECONF  = 2;

	localparam logic [4:0] TBL_DIAG_BASE = 5'h08;
	localparam logic [4:0] TBL_STAT_BASE = 5'h14;
	localparam logic [31:0] DIAG_MASK = 32'h003F_001F;
	localparam logic [3:0] DIAG_WORDS = 4'hC;
	localparam logic [5:0] STATUS_BITS = 6'h20;

	typedef enum logic [1:0] {OUT_LIVE, OUT_FORCED, OUT_HELD} aioc_out_t;
endpackage : aioc_pkg
`default_nettype wire

//--- aioc_sync.sv
// Two-stage synchroniser for asynchronous event levels
`default_nettype none
module aioc_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} aioc_sync_t;

	aioc_sync_t state_reg;
	aioc_sync_t state_next;

	always_comb begin
		state_next.s1 = d;
		state_next.s2 = state_reg.s1;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign q = state_reg.s2;

	sync_delay_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		$past(resetn, 2) |-> q == $past(d, 2))
		else $error("synchroniser output is not the input two cycles back");
endmodule : aioc_sync
`default_nettype wire

//--- aioc_fmt.sv
// Channel value formatter: float passes through, integer sign-extends the low word
`default_nettype none
module aioc_fmt (
	input  wire logic        fmt_int,
	input  wire logic [31:0] raw,
	output logic      [31:0] val
);
	// The high word never reaches the value in integer mode, whatever it holds
	always_comb begin
		if (fmt_int) begin
			val = {{16{raw[15]}}, raw[15:0]};
		end else begin
			val = raw;
		end
	end
endmodule : aioc_fmt
`default_nettype wire

//--- aioc_top.sv
// Analog I/O channel configuration, value tables, output defaulting and status
`default_nettype none
module aioc_top (
	input  wire logic                         sys_clk,
	input  wire logic                         resetn,
	input  wire logic [7:0]                   reg_addr,
	input  wire logic [31:0]                  reg_wdata,
	input  wire logic                         reg_we,
	input  wire logic                         reg_re,
	output logic      [31:0]                  reg_rdata,
	output logic                              irq,
	input  wire logic                         scan_tick,
	input  wire logic                         aq_we,
	input  wire logic [1:0]                   aq_addr,
	input  wire logic [15:0]                  aq_wdata,
	input  wire logic                         tbl_re,
	input  wire logic [4:0]                   tbl_addr,
	output logic      [15:0]                  tbl_rdata,
	input  wire logic [aioc_pkg::N_IN*32-1:0] adc_raw,
	input  wire logic [aioc_pkg::N_CH*32-1:0] ch_diag_raw,
	input  wire logic                         ev_stop_dis,
	input  wire logic                         ev_run_dis,
	input  wire logic                         ev_bp_power_loss,
	input  wire logic                         ev_mod_fatal,
	input  wire logic                         ev_cpu_critical,
	input  wire logic                         ev_cfg_clear,
	input  wire logic                         mod_failed,
	output logic      [aioc_pkg::N_OUT*32-1:0] dac_value,
	output logic      [aioc_pkg::N_OUT-1:0]   dac_enable,
	output logic      [aioc_pkg::N_OUT*2-1:0] dac_range,
	output logic      [3:0]                   diag_len_words,
	output logic      [5:0]                   status_len_bits
);
	typedef struct packed {
		logic [31:0]                              ctrl;
		logic [31:0]                              ocfg;
		logic [aioc_pkg::N_CH-1:0]                chen_diag;
		logic [aioc_pkg::N_CH-1:0]                chen_flt;
		logic [aioc_pkg::N_IRQ-1:0]               int_stat;
		logic [aioc_pkg::N_IRQ-1:0]               int_mask;
		logic [aioc_pkg::N_OUT-1:0][31:0]         dflt;
		logic [2*aioc_pkg::N_OUT-1:0][15:0]       aq;
		logic [aioc_pkg::N_IN-1:0][31:0]          ai_snap;
		logic [aioc_pkg::N_CH-1:0][31:0]          diag_snap;
		logic [31:0]                              stat_snap;
		aioc_pkg::aioc_out_t                      out_st;
		logic [aioc_pkg::N_OUT-1:0][31:0]         dac;
		logic [aioc_pkg::N_OUT-1:0]               dac_en;
		logic [aioc_pkg::N_OUT-1:0][1:0]          dac_rng;
		logic [3:0]                               diag_len;
		logic [5:0]                               stat_bits;
		logic [31:0]                              rdata;
		logic [15:0]                              tdata;
		logic                                     irq;
		logic                                     trig_q;
		logic                                     fail_q;
	} aioc_state_t;

	aioc_state_t state_reg;
	aioc_state_t state_next;

	logic [aioc_pkg::N_EV-1:0]          ev_s;
	logic                               fail_s;
	logic                               trig;
	logic                               reconf_req;
	logic [aioc_pkg::N_IRQ-1:0]         irq_set;
	logic [aioc_pkg::N_IN-1:0][31:0]    in_val;
	logic [aioc_pkg::N_OUT-1:0][31:0]   out_val;
	logic [aioc_pkg::N_CH-1:0]          flt_any;
	logic [31:0]                        stat_word;
	logic [4:0]                         toff;
	logic                               fmt_int;
	logic                               mod_diag;
	logic                               stat_on;

	aioc_sync #(
		.W(aioc_pkg::N_EV + 1)
	) u_sync (
		.sys_clk(sys_clk),
		.resetn (resetn),
		.d      ({mod_failed, ev_cfg_clear, ev_cpu_critical, ev_mod_fatal,
		          ev_bp_power_loss, ev_run_dis, ev_stop_dis}),
		.q      ({fail_s, ev_s})
	);

	assign fmt_int  = state_reg.ctrl[aioc_pkg::CTRL_FMT_INT];
	assign mod_diag = state_reg.ctrl[aioc_pkg::CTRL_MOD_DIAG];
	assign stat_on  = state_reg.ctrl[aioc_pkg::CTRL_STLEN_LSB +: 8] == aioc_pkg::STATUS_LEN_ON;

	genvar gi;
	generate
		for (gi = 0; gi < aioc_pkg::N_IN; gi++) begin : g_in
			aioc_fmt u_fmt (
				.fmt_int(fmt_int),
				.raw    (adc_raw[gi*32 +: 32]),
				.val    (in_val[gi])
			);
		end
		for (gi = 0; gi < aioc_pkg::N_OUT; gi++) begin : g_out
			aioc_fmt u_fmt (
				.fmt_int(fmt_int),
				.raw    ({state_reg.aq[2*gi+1], state_reg.aq[2*gi]}),
				.val    (out_val[gi])
			);
		end
		for (gi = 0; gi < aioc_pkg::N_CH; gi++) begin : g_flt
			assign flt_any[gi] = |(ch_diag_raw[gi*32 +: 32] & aioc_pkg::DIAG_MASK);
		end
	endgenerate

	always_comb begin
		state_next = state_reg;
		// Events arrive two edges late; the forced value lands two edges after that
		trig       = |ev_s;
		reconf_req = reg_we && reg_addr == aioc_pkg::OFF_RECONF && reg_wdata[0];
		toff       = tbl_addr - aioc_pkg::TBL_DIAG_BASE;
		stat_word  = '0;
		stat_word[aioc_pkg::N_EV-1:0] = ev_s;
		stat_word[6] = fail_s;
		stat_word[7] = state_reg.out_st != aioc_pkg::OUT_LIVE;
		stat_word[aioc_pkg::CHEN_FLT_LSB +: aioc_pkg::N_CH] = state_reg.chen_flt & flt_any;

		// Register writes
		if (reg_we) begin
			case (reg_addr)
				aioc_pkg::OFF_CTRL: begin
					state_next.ctrl = reg_wdata & aioc_pkg::CTRL_WMASK;
					// Any length but 0 or 32 leaves the old length in place
					if (reg_wdata[aioc_pkg::CTRL_STLEN_LSB +: 8] != 8'h00 &&
					    reg_wdata[aioc_pkg::CTRL_STLEN_LSB +: 8] != aioc_pkg::STATUS_LEN_ON) begin
						state_next.ctrl[aioc_pkg::CTRL_STLEN_LSB +: 8] =
							state_reg.ctrl[aioc_pkg::CTRL_STLEN_LSB +: 8];
					end
				end
				aioc_pkg::OFF_OCFG: state_next.ocfg = reg_wdata;
				aioc_pkg::OFF_CHEN: begin
					state_next.chen_diag = reg_wdata[aioc_pkg::N_CH-1:0];
					state_next.chen_flt  = reg_wdata[aioc_pkg::CHEN_FLT_LSB +: aioc_pkg::N_CH];
				end
				aioc_pkg::OFF_INT_STAT: state_next.int_stat = state_reg.int_stat &
					~reg_wdata[aioc_pkg::N_IRQ-1:0];
				aioc_pkg::OFF_INT_MASK: state_next.int_mask = reg_wdata[aioc_pkg::N_IRQ-1:0];
				aioc_pkg::OFF_DFLT0: state_next.dflt[0] = reg_wdata;
				aioc_pkg::OFF_DFLT1: state_next.dflt[1] = reg_wdata;
				default: ;
			endcase
		end

		// Output default state machine
		state_next.trig_q = trig;
		state_next.fail_q = fail_s;
		case (state_reg.out_st)
			aioc_pkg::OUT_LIVE: begin
				if (trig) begin
					state_next.out_st = state_reg.ctrl[aioc_pkg::CTRL_OUT_HOLD] ?
						aioc_pkg::OUT_HELD : aioc_pkg::OUT_FORCED;
				end
			end
			aioc_pkg::OUT_FORCED, aioc_pkg::OUT_HELD: begin
				// A reconfiguration while an event persists does not count as successful
				if (reconf_req && !trig) begin
					state_next.out_st = aioc_pkg::OUT_LIVE;
				end
			end
			default: state_next.out_st = aioc_pkg::OUT_LIVE;
		endcase

		// Event flags: the set is applied after the clear so that it wins
		irq_set = '0;
		irq_set[aioc_pkg::IRQ_DEFAULT] = trig && !state_reg.trig_q;
		irq_set[aioc_pkg::IRQ_FAIL]    = fail_s && !state_reg.fail_q;
		irq_set[aioc_pkg::IRQ_RECONF]  = reconf_req && !trig &&
			state_reg.out_st != aioc_pkg::OUT_LIVE;
		state_next.int_stat = state_next.int_stat | irq_set;
		state_next.irq = |(state_next.int_stat & state_next.int_mask);

		// Output table words from the controller
		if (aq_we) begin
			state_next.aq[aq_addr] = aq_wdata;
		end

		// Output channels
		for (int c = 0; c < aioc_pkg::N_OUT; c++) begin
			state_next.dac_rng[c] = state_reg.ocfg[c*aioc_pkg::OCFG_STRIDE +
				aioc_pkg::OCFG_RNG +: 2];
			if (!state_reg.ocfg[c*aioc_pkg::OCFG_STRIDE + aioc_pkg::OCFG_EN]) begin
				state_next.dac_en[c] = 1'b0;
				state_next.dac[c]    = '0;
			end else begin
				state_next.dac_en[c] = 1'b1;
				case (state_reg.out_st)
					aioc_pkg::OUT_LIVE: begin
						if (scan_tick) begin
							state_next.dac[c] = out_val[c];
						end
					end
					aioc_pkg::OUT_FORCED: state_next.dac[c] = state_reg.dflt[c];
					aioc_pkg::OUT_HELD:   state_next.dac[c] = state_reg.dac[c];
					default:              state_next.dac[c] = state_reg.dac[c];
				endcase
			end
		end

		// Input snapshot, diagnostics and status, taken once per scan
		// Hold mode simply skips the update, so the last snapshot stays visible
		if (fail_s) begin
			if (!state_reg.ctrl[aioc_pkg::CTRL_IN_HOLD]) begin
				state_next.ai_snap = '0;
			end
		end else if (scan_tick) begin
			state_next.ai_snap = in_val;
		end
		if (scan_tick) begin
			for (int c = 0; c < aioc_pkg::N_CH; c++) begin
				state_next.diag_snap[c] = (mod_diag && state_reg.chen_diag[c]) ?
					ch_diag_raw[c*32 +: 32] & aioc_pkg::DIAG_MASK : 32'h0000_0000;
			end
			state_next.stat_snap = stat_on ? stat_word : 32'h0000_0000;
		end
		state_next.diag_len  = mod_diag ? aioc_pkg::DIAG_WORDS : 4'h0;
		state_next.stat_bits = stat_on ? aioc_pkg::STATUS_BITS : 6'h00;

		// Table read port: values, then diagnostics, then status, two words each
		state_next.tdata = 16'h0000;
		if (tbl_re) begin
			if (tbl_addr < aioc_pkg::TBL_DIAG_BASE) begin
				state_next.tdata = tbl_addr[0] ? state_reg.ai_snap[tbl_addr[2:1]][31:16] :
					state_reg.ai_snap[tbl_addr[2:1]][15:0];
			end else if (tbl_addr < aioc_pkg::TBL_STAT_BASE) begin
				state_next.tdata = toff[0] ? state_reg.diag_snap[toff[4:1]][31:16] :
					state_reg.diag_snap[toff[4:1]][15:0];
			end else if (tbl_addr < aioc_pkg::TBL_STAT_BASE + 5'h02) begin
				state_next.tdata = tbl_addr[0] ? state_reg.stat_snap[31:16] :
					state_reg.stat_snap[15:0];
			end
		end

		// Register read port, data valid in the following cycle only
		state_next.rdata = 32'h0000_0000;
		if (reg_re) begin
			case (reg_addr)
				aioc_pkg::OFF_CTRL:     state_next.rdata = state_reg.ctrl;
				aioc_pkg::OFF_OCFG:     state_next.rdata = state_reg.ocfg;
				aioc_pkg::OFF_CHEN: begin
					state_next.rdata[aioc_pkg::N_CH-1:0] = state_reg.chen_diag;
					state_next.rdata[aioc_pkg::CHEN_FLT_LSB +: aioc_pkg::N_CH] =
						state_reg.chen_flt;
				end
				aioc_pkg::OFF_INT_STAT: state_next.rdata[aioc_pkg::N_IRQ-1:0] = state_reg.int_stat;
				aioc_pkg::OFF_INT_MASK: state_next.rdata[aioc_pkg::N_IRQ-1:0] = state_reg.int_mask;
				aioc_pkg::OFF_STATE: begin
					state_next.rdata[7:0] = stat_word[7:0];
					state_next.rdata[9:8] = state_reg.out_st;
				end
				aioc_pkg::OFF_DFLT0:    state_next.rdata = state_reg.dflt[0];
				aioc_pkg::OFF_DFLT1:    state_next.rdata = state_reg.dflt[1];
				default:                state_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_reg        <= '0;
			state_reg.ctrl   <= aioc_pkg::CTRL_RST;
			state_reg.ocfg   <= aioc_pkg::OCFG_RST;
			state_reg.out_st <= aioc_pkg::OUT_LIVE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata       = state_reg.rdata;
	assign irq             = state_reg.irq;
	assign tbl_rdata       = state_reg.tdata;
	assign dac_value       = state_reg.dac;
	assign dac_enable      = state_reg.dac_en;
	assign dac_range       = state_reg.dac_rng;
	assign diag_len_words  = state_reg.diag_len;
	assign status_len_bits = state_reg.stat_bits;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	in_force_off_a: assert property (
		fail_s && !state_reg.ctrl[aioc_pkg::CTRL_IN_HOLD] |=> state_reg.ai_snap == '0)
		else $error("input values not cleared on module failure");
	in_hold_a: assert property (
		fail_s && state_reg.ctrl[aioc_pkg::CTRL_IN_HOLD] |=> $stable(state_reg.ai_snap))
		else $error("input values changed while held on module failure");
	status_len_a: assert property (
		reg_we && reg_addr == aioc_pkg::OFF_CTRL && reg_wdata[15:8] != 8'h00 &&
		reg_wdata[15:8] != 8'h20 |=> $stable(state_reg.ctrl[15:8]))
		else $error("illegal status length accepted");
	diag_alloc_a: assert property (
		mod_diag |=> diag_len_words == 4'hC)
		else $error("diagnostic length not twelve words with diagnostics on");
	tbl_high_word_a: assert property (
		tbl_re && tbl_addr == 5'h01 |=> tbl_rdata == $past(state_reg.ai_snap[0][31:16]))
		else $error("table high word of channel zero wrong");
	out_disabled_a: assert property (
		!state_reg.ocfg[0] |=> !dac_enable[0] && dac_value[31:0] == 32'h0000_0000)
		else $error("disabled output channel drives");
	out_range_a: assert property (
		1'b1 |=> dac_range[3:2] == $past(state_reg.ocfg[6:5]))
		else $error("output range does not follow configuration");
	int_low_word_a: assert property (
		scan_tick && fmt_int && state_reg.ocfg[0] && state_reg.out_st == aioc_pkg::OUT_LIVE
		|=> dac_value[31:0] == {{16{$past(state_reg.aq[0][15])}}, $past(state_reg.aq[0])})
		else $error("integer output not taken from low word");
	force_default_a: assert property (
		trig && !state_reg.ctrl[aioc_pkg::CTRL_OUT_HOLD] && state_reg.ocfg[0] && !reg_we &&
		state_reg.out_st != aioc_pkg::OUT_HELD |-> ##2 dac_value[31:0] == $past(state_reg.dflt[0]))
		else $error("output not forced to default two cycles after event");
	fmt_reset_a: assert property (
		$rose(resetn) |-> !fmt_int && !mod_diag)
		else $error("format or diagnostics not at reset default");
	in_sign_ext_a: assert property (
		scan_tick && fmt_int && !fail_s |=>
		state_reg.ai_snap[0][31:16] == {16{state_reg.ai_snap[0][15]}})
		else $error("integer input upper word not sign extension");
	out_hold_a: assert property (
		state_reg.out_st == aioc_pkg::OUT_HELD && state_reg.ocfg[0] |=> $stable(dac_value[31:0]))
		else $error("held output changed");
	scan_snap_a: assert property (
		!scan_tick && !fail_s |=> $stable(state_reg.ai_snap) && $stable(state_reg.stat_snap))
		else $error("snapshot changed outside a scan");
	out_trigger_a: assert property (
		trig && state_reg.out_st == aioc_pkg::OUT_LIVE |=> state_reg.out_st != aioc_pkg::OUT_LIVE)
		else $error("output default action not taken on event");
	diag_gate_a: assert property (
		scan_tick && !mod_diag |=> state_reg.diag_snap == '0)
		else $error("diagnostics reported with module diagnostics off");

	forced_c:  cover property (state_reg.out_st == aioc_pkg::OUT_FORCED ##1 irq);
	held_c:    cover property (state_reg.out_st == aioc_pkg::OUT_HELD ##1
		state_reg.out_st == aioc_pkg::OUT_LIVE);
	fail_c:    cover property ($rose(fail_s) ##1 state_reg.ai_snap == '0);
	reconf_c:  cover property (state_reg.int_stat[aioc_pkg::IRQ_RECONF]);
	ch1_forced_c: cover property (state_reg.out_st == aioc_pkg::OUT_FORCED && dac_enable[1]);
endmodule : aioc_top
`default_nettype wire

//--- aioc_cpu_model.sv
// Controller-side model: scan pulses, output table writes, input table reads
`default_nettype none
module aioc_cpu_model (
	input  wire logic        sys_clk,
	output logic             scan_tick,
	output logic             aq_we,
	output logic      [1:0]  aq_addr,
	output logic      [15:0] aq_wdata,
	output logic             tbl_re,
	output logic      [4:0]  tbl_addr,
	input  wire logic [15:0] tbl_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scan_tick = 1'b0;
		aq_we = 1'b0;
		aq_addr = 2'h0;
		aq_wdata = 16'h0;
		tbl_re = 1'b0;
		tbl_addr = 5'h00;
	end
	task automatic scan();
		@(posedge sys_clk);
		scan_tick <= 1'b1;
		@(posedge sys_clk);
		scan_tick <= 1'b0;
	endtask : scan
	// A 16-bit word cannot leave -32768..+32767, so integer writes stay legal
	task automatic aq_put(input logic [1:0] a, input logic [15:0] w);
		@(posedge sys_clk);
		aq_we <= 1'b1;
		aq_addr <= a;
		aq_wdata <= w;
		@(posedge sys_clk);
		aq_we <= 1'b0;
		aq_wdata <= ~w;
	endtask : aq_put
	task automatic tbl_get(input logic [4:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		tbl_re <= 1'b1;
		tbl_addr <= a;
		@(posedge sys_clk);
		tbl_re <= 1'b0;
		tbl_addr <= ~a;
		#1 d = tbl_rdata;
	endtask : tbl_get
endmodule : aioc_cpu_model
`default_nettype wire

//--- aioc_bench.sv
// Self-checking bench for the analog I/O channel configuration block
`default_nettype none
module aioc_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic         sys_clk = 1'b0;
	logic         resetn = 1'b0;
	logic [7:0]   reg_addr = 8'h00;
	logic [31:0]  reg_wdata = 32'h0;
	logic         reg_we = 1'b0;
	logic         reg_re = 1'b0;
	logic [127:0] adc_raw = 128'h0;
	logic [191:0] ch_diag_raw = '1;
	logic [5:0]   ev = 6'h00;
	logic         mod_failed = 1'b0;
	logic [31:0]  reg_rdata;
	logic         irq;
	logic         scan_tick;
	logic         aq_we;
	logic [1:0]   aq_addr;
	logic [15:0]  aq_wdata;
	logic         tbl_re;
	logic [4:0]   tbl_addr;
	logic [15:0]  tbl_rdata;
	logic [63:0]  dac_value;
	logic [1:0]   dac_enable;
	logic [3:0]   dac_range;
	logic [3:0]   diag_len_words;
	logic [5:0]   status_len_bits;
	logic [15:0]  t;
	int           n_errors = 0;
	int           checks = 0;
	always #20 sys_clk = ~sys_clk;
	aioc_top u_aioc_top (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_we, .reg_re,
		.reg_rdata, .irq, .scan_tick, .aq_we, .aq_addr, .aq_wdata, .tbl_re, .tbl_addr,
		.tbl_rdata, .adc_raw, .ch_diag_raw, .ev_stop_dis(ev[0]), .ev_run_dis(ev[1]),
		.ev_bp_power_loss(ev[2]), .ev_mod_fatal(ev[3]), .ev_cpu_critical(ev[4]),
		.ev_cfg_clear(ev[5]), .mod_failed, .dac_value, .dac_enable, .dac_range,
		.diag_len_words, .status_len_bits);
	aioc_cpu_model u_aioc_cpu_model (.sys_clk, .scan_tick, .aq_we, .aq_addr, .aq_wdata,
		.tbl_re, .tbl_addr, .tbl_rdata);
	task automatic conclude();
		$display("errors %0d, checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_we <= 1'b0;
		reg_wdata <= ~v;
	endtask : wr
	task automatic rg(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_re <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rg
	task automatic tg(input logic [4:0] a, input logic [15:0] e);
		u_aioc_cpu_model.tbl_get(a, t);
		chk({16'h0, t}, {16'h0, e});
	endtask : tg
	task automatic scan();
		u_aioc_cpu_model.scan();
		cyc(3);
	endtask : scan
	task automatic t_config();
		rg(aioc_pkg::OFF_CTRL, aioc_pkg::CTRL_RST);
		rg(aioc_pkg::OFF_OCFG, aioc_pkg::OCFG_RST);
		rg(8'h3C, 32'h0);
		chk({28'h0, diag_len_words}, 32'h0);
		wr(aioc_pkg::OFF_CTRL, 32'h0000_1008);
		cyc(2);
		chk({26'h0, status_len_bits}, 32'h0);
		chk({28'h0, diag_len_words}, {28'h0, aioc_pkg::DIAG_WORDS});
		wr(aioc_pkg::OFF_CHEN, 32'h0000_3F3F);
		scan();
		tg(aioc_pkg::TBL_DIAG_BASE + 5'h0A, 16'h001F);
		tg(aioc_pkg::TBL_DIAG_BASE + 5'h0B, 16'h003F);
		wr(aioc_pkg::OFF_CTRL, 32'h0000_2000);
		cyc(2);
		chk({26'h0, status_len_bits}, {26'h0, aioc_pkg::STATUS_BITS});
	endtask : t_config
	task automatic t_out();
		for (int r = 0; r < 4; r++) begin
			wr(aioc_pkg::OFF_OCFG, 32'(r * 2 + 1));
			cyc(2);
			chk({30'h0, dac_range[1:0]}, 32'(r));
			chk({30'h0, dac_enable}, 32'h1);
		end
		u_aioc_cpu_model.aq_put(2'h0, 16'h8001);
		u_aioc_cpu_model.aq_put(2'h1, 16'h1234);
		scan();
		chk(dac_value[31:0], 32'h1234_8001);
		wr(aioc_pkg::OFF_CTRL, 32'h0000_0004);
		scan();
		chk(dac_value[31:0], 32'hFFFF_8001);
		u_aioc_cpu_model.aq_put(2'h0, 16'h7FFF);
		scan();
		chk(dac_value[31:0], 32'h0000_7FFF);
		adc_raw[63:0] <= 64'h4049_0FDB_0000_FFFE;
		scan();
		tg(5'h00, 16'hFFFE);
		tg(5'h01, 16'hFFFF);
		tg(5'h03, 16'h0000);
		wr(aioc_pkg::OFF_CTRL, 32'h0);
		scan();
		tg(5'h03, 16'h4049);
	endtask : t_out
	task automatic t_events();
		wr(aioc_pkg::OFF_DFLT0, 32'h1111_2222);
		wr(aioc_pkg::OFF_INT_MASK, 32'h1);
		for (int i = 0; i < 6; i++) begin
			ev <= 6'(1 << i);
			cyc(5);
			chk(dac_value[31:0], 32'h1111_2222);
			chk({31'h0, irq}, 32'h1);
			wr(aioc_pkg::OFF_RECONF, 32'h1);
			ev <= 6'h00;
			scan();
			chk(dac_value[31:0], 32'h1111_2222);
			wr(aioc_pkg::OFF_INT_STAT, 32'h7);
			wr(aioc_pkg::OFF_RECONF, 32'h1);
			scan();
			chk({31'h0, irq}, 32'h0);
			chk(dac_value[31:0], 32'h1234_7FFF);
		end
	endtask : t_events
	task automatic t_hold();
		wr(aioc_pkg::OFF_CTRL, 32'h0000_0002);
		ev <= 6'h08;
		cyc(5);
		u_aioc_cpu_model.aq_put(2'h0, 16'h5555);
		scan();
		chk(dac_value[31:0], 32'h1234_7FFF);
		ev <= 6'h00;
		cyc(4);
		wr(aioc_pkg::OFF_RECONF, 32'h1);
		scan();
		chk(dac_value[31:0], 32'h1234_5555);
	endtask : t_hold
	task automatic t_ch1();
		wr(aioc_pkg::OFF_INT_STAT, 32'h7);
		wr(aioc_pkg::OFF_CTRL, 32'h0000_2000);
		wr(aioc_pkg::OFF_OCFG, 32'h0000_0050);
		wr(aioc_pkg::OFF_DFLT1, 32'h3333_4444);
		u_aioc_cpu_model.aq_put(2'h2, 16'hBEEF);
		u_aioc_cpu_model.aq_put(2'h3, 16'hCAFE);
		scan();
		chk({30'h0, dac_enable}, 32'h2);
		chk({30'h0, dac_range[3:2]}, {30'h0, aioc_pkg::RNG_4_20MA});
		chk(dac_value[63:32], 32'hCAFE_BEEF);
		chk(dac_value[31:0], 32'h0);
		ev <= 6'h04;
		cyc(5);
		chk(dac_value[63:32], 32'h3333_4444);
		chk({31'h0, irq}, 32'h1);
		rg(aioc_pkg::OFF_STATE, 32'h0000_0184);
		rg(aioc_pkg::OFF_INT_STAT, 32'h1);
		scan();
		tg(aioc_pkg::TBL_STAT_BASE, 16'h3F84);
		tg(aioc_pkg::TBL_STAT_BASE + 5'h01, 16'h0000);
		ev <= 6'h00;
		cyc(4);
		wr(aioc_pkg::OFF_RECONF, 32'h1);
		scan();
		chk(dac_value[63:32], 32'hCAFE_BEEF);
	endtask : t_ch1
	task automatic t_in_fail();
		adc_raw[31:0] <= 32'h0000_0123;
		wr(aioc_pkg::OFF_CTRL, 32'h0);
		mod_failed <= 1'b1;
		cyc(4);
		scan();
		tg(5'h00, 16'h0000);
		mod_failed <= 1'b0;
		wr(aioc_pkg::OFF_CTRL, 32'h1);
		cyc(4);
		scan();
		tg(5'h00, 16'h0123);
		mod_failed <= 1'b1;
		cyc(4);
		adc_raw[31:0] <= 32'h0000_0456;
		scan();
		tg(5'h00, 16'h0123);
		mod_failed <= 1'b0;
	endtask : t_in_fail
	initial begin
		cyc(20);
		resetn <= 1'b1;
		t_config();
		t_out();
		t_events();
		t_hold();
		t_ch1();
		t_in_fail();
		conclude();
	end
endmodule : aioc_bench
`default_nettype wire
